// file: inc/ssr_pkg.sv
// constants for the clock-synchronous serial slave receiver
// assumes one 100 MHz clock and a 16-bit plain register port
package ssr_pkg;

	// ==========================================================
	// register port
	localparam int ADDR_W = 5;                // register index width
	localparam int DATA_W = 16;               // register data width

	localparam logic [4:0] OFS_CONTROL   = 5'h00; // serial_control_reg
	localparam logic [4:0] OFS_MODE      = 5'h01; // serial_mode_reg
	localparam logic [4:0] OFS_BITRATE   = 5'h02; // bit_rate_divider
	localparam logic [4:0] OFS_SMART     = 5'h03; // smart_interface_mode_reg
	localparam logic [4:0] OFS_I2C       = 5'h04; // simple_i2c_mode_reg
	localparam logic [4:0] OFS_SPI       = 5'h05; // simple_spi_mode_reg
	localparam logic [4:0] OFS_RXDATA    = 5'h06; // receive data, read only
	localparam logic [4:0] OFS_STATUS    = 5'h07; // receive status flags
	localparam logic [4:0] OFS_KEY       = 5'h08; // write_protect_key_reg
	localparam logic [4:0] OFS_STOP      = 5'h09; // channel stop control
	localparam logic [4:0] OFS_PINPROT   = 5'h0a; // pin_select_protect_reg
	localparam logic [4:0] OFS_RXPIN     = 5'h0b; // rx_pin_function_sel
	localparam logic [4:0] OFS_CLKPIN    = 5'h0c; // clk_pin_function_sel
	localparam logic [4:0] OFS_IRQ_STAT  = 5'h0d; // sticky event bits
	localparam logic [4:0] OFS_IRQ_MASK  = 5'h0e; // event mask
	localparam logic [4:0] OFS_GRP_EN    = 5'h0f; // error_group_enable
	localparam logic [4:0] OFS_GRP_MEM   = 5'h10; // group_member_enable_reg
	localparam logic [4:0] OFS_GRP_STAT  = 5'h11; // group source, read only

	// ==========================================================
	// field positions
	localparam int CTRL_RIE      = 6;         // receive interrupt enable
	localparam int CTRL_RE       = 4;         // receive enable
	localparam int MODE_SYNC     = 7;         // comm_mode_bit
	localparam int SMART_ORDER   = 3;         // bit_order_sel
	localparam int SMART_INVERT  = 2;         // data_invert_sel
	localparam int SMART_CARD    = 0;         // smart_card_sel
	localparam int I2C_ENABLE    = 0;         // simple_i2c_enable
	localparam int SPI_PHASE     = 7;         // clock_phase_sel
	localparam int SPI_POL       = 6;         // clock_polarity_sel
	localparam int KEY_STOP_OPEN = 1;         // opens channel stop writes
	localparam int PIN_LOCK      = 7;         // pin_select_lock
	localparam int PIN_WE        = 6;         // pin_select_write_enable
	localparam int ST_FULL       = 0;         // rx_full_request_flag
	localparam int ST_OVR        = 1;         // overrun_flag
	localparam int ST_BITDONE    = 2;         // one bit period elapsed

	// ==========================================================
	// codes and reset values
	localparam logic [7:0] KEY_CODE      = 8'ha5;  // upper byte of a key write
	localparam logic [1:0] CKE_EXTERNAL  = 2'b10;  // clock from serial_clock_pin
	localparam logic [5:0] PIN_FUNC_SCI  = 6'h0a;  // pin routed to this block
	localparam logic [7:0] BITRATE_RST   = 8'hff;
	localparam logic [7:0] PINPROT_RST   = 8'h80;  // locked after reset
	localparam logic       STOP_RST      = 1'b1;   // channel starts stopped

	// ==========================================================
	// timing
	localparam int CLK_MHZ       = 100;       // mclk rate
	localparam int BRG_BASE      = 4;         // clocks per divider step at prescale 0
	localparam int WORD_BITS     = 8;         // bits per serial word
	localparam int PERIOD_W      = 17;        // holds 4*256*64 clocks

endpackage : ssr_pkg

// file: logic/serial_clock_edge.sv
// sampling-edge detector for the external serial clock
// assumes the clock pin is already synchronous to mclk
`timescale 1ns/1ps
module serial_clock_edge
(
	input  wire logic mclk,          // system clock
	input  wire logic rstn,          // async reset, active low
	input  wire logic pin_clk,       // serial_clock_pin level
	input  wire logic polarity,      // clock_polarity_sel
	input  wire logic phase,         // clock_phase_sel
	output logic      sample         // one-cycle pulse on the sampling edge
);

	logic prev_clk;                  // effective clock one cycle ago
	wire  eff_clk = pin_clk ^ polarity; // polarity folded in
	wire  rise    = eff_clk & ~prev_clk;
	wire  fall    = ~eff_clk & prev_clk;

	// ==========================================================
	// previous level, idle level of the effective clock is high
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			prev_clk <= 1'b1;
		else
			prev_clk <= eff_clk;
	end

	// default timing samples on the rising edge, phase swaps it
	assign sample = phase ? fall : rise; // (RULE7)

endmodule : serial_clock_edge

// file: logic/rx_word_shifter.sv
// eight-bit receive shifter with bit order and inversion options
// assumes sample is a one-cycle pulse per serial bit
`timescale 1ns/1ps
module rx_word_shifter
#(
	parameter int BITS = ssr_pkg::WORD_BITS  // serial word length
)
(
	input  wire logic            mclk,       // system clock
	input  wire logic            rstn,       // async reset, active low
	input  wire logic            clear,      // drop a partial word
	input  wire logic            sample,     // take one bit now
	input  wire logic            bit_in,     // serial_rx_pin level
	input  wire logic            msb_first,  // bit_order_sel
	input  wire logic            invert,     // data_invert_sel
	output logic [BITS-1:0]      word,       // assembled word
	output logic                 done        // pulse with last bit
);

	localparam int CNT_W = $clog2(BITS);
	logic [CNT_W-1:0] count;                 // bits taken so far
	logic [BITS-1:0]  shift;                 // assembly register
	wire              data_bit = bit_in ^ invert; // (RULE5)
	wire              last     = (count == CNT_W'(BITS - 1));
	wire [BITS-1:0]   next_shift = msb_first ? {shift[BITS-2:0], data_bit}
	                                         : {data_bit, shift[BITS-1:1]}; // (RULE1)

	// ==========================================================
	// bit counter and shift register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			count <= '0;
			shift <= '0;
		end
		else if (clear)
			count <= '0;                     // partial word lost
		else if (sample)
		begin
			shift <= next_shift;
			count <= last ? '0 : count + CNT_W'(1); // (RULE15)
		end
	end

	// word is registered together with the done pulse
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			word <= '0;
			done <= 1'b0;
		end
		else
		begin
			done <= sample & last & ~clear;
			if (sample & last)
				word <= next_shift;
		end
	end

endmodule : rx_word_shifter

// file: logic/sync_serial_slave_receiver.sv
// clock-synchronous serial slave receiver with its control registers
// assumes a plain register port and pins synchronous to mclk
// What this block does
// (RULE1) bit order zero assembles LSB first
// (RULE2) clock select 10b takes external clock pin
// (RULE3) mode bit one selects clock-synchronous operation
// (RULE4) prescale zero, divider 119 gives a 480-clock bit period
// (RULE5) inversion zero passes bits unchanged
// (RULE6) smart card select zero means plain serial
// (RULE7) default phase and polarity, no I2C mode
// (RULE8) software waits one bit period before enabling
// (RULE9) cleared control bits read back as zero
// (RULE10) channel stop bit changes only with key open
// (RULE11) full flag set when word ready
// (RULE12) error request gated by group and member enables
// (RULE13) pin selectors writable only while write-enabled
// (RULE14) overrun is the only receive error
// (RULE15) one bit per clock, overrun if unread
// (RULE16) master drives clock and valid data
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module sync_serial_slave_receiver
#(
	parameter int PERIOD_W = ssr_pkg::PERIOD_W  // bit period counter width
)
(
	input  wire logic                       mclk,             // system clock
	input  wire logic                       rstn,             // async reset, active low
	input  wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,         // register index
	input  wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,        // write data
	input  wire logic                       reg_write,        // write strobe
	input  wire logic                       reg_read,         // read strobe
	output logic      [ssr_pkg::DATA_W-1:0] reg_rdata,        // read data, next cycle
	input  wire logic                       serial_clock_pin, // clock from master
	input  wire logic                       serial_rx_pin,    // data from master
	output logic                            rx_full_request,  // receive-full request
	output logic                            rx_error_request, // grouped error request
	output logic                            irq               // masked sticky events
);

	// ==========================================================
	// register storage
	logic [7:0] serial_control_reg;       // enables and clock select
	logic [7:0] serial_mode_reg;          // mode and prescaler
	logic [7:0] bit_rate_divider;         // divider value
	logic [7:0] smart_interface_mode_reg; // order, inversion, smart card
	logic [7:0] simple_i2c_mode_reg;      // simple I2C enable
	logic [7:0] simple_spi_mode_reg;      // phase and polarity
	logic [7:0] rx_data;                  // last accepted word
	logic       rx_full_request_flag;     // word waiting
	logic       overrun_flag;             // word lost
	logic       bit_period_done;          // one bit period since config
	logic [7:0] write_protect_key_reg;    // low byte of the key
	logic       channel_stop_bit;         // channel held in stop
	logic [7:0] pin_select_protect_reg;   // lock and write enable
	logic [5:0] rx_pin_function_sel;      // data pin function
	logic [5:0] clk_pin_function_sel;     // clock pin function
	logic [1:0] irq_status;               // sticky full and overrun events
	logic [1:0] irq_mask;                 // enables for irq
	logic       error_group_enable;       // group enable
	logic       group_member_enable_reg;  // channel member enable
	logic [PERIOD_W-1:0] period_count;    // bit period timer

	// ==========================================================
	// decode, one function reused for every register
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	wire wr_control = reg_write & hit(reg_addr, ssr_pkg::OFS_CONTROL);
	wire wr_mode    = reg_write & hit(reg_addr, ssr_pkg::OFS_MODE);
	wire wr_bitrate = reg_write & hit(reg_addr, ssr_pkg::OFS_BITRATE);
	wire wr_smart   = reg_write & hit(reg_addr, ssr_pkg::OFS_SMART);
	wire wr_i2c     = reg_write & hit(reg_addr, ssr_pkg::OFS_I2C);
	wire wr_spi     = reg_write & hit(reg_addr, ssr_pkg::OFS_SPI);
	wire wr_status  = reg_write & hit(reg_addr, ssr_pkg::OFS_STATUS);
	wire wr_key     = reg_write & hit(reg_addr, ssr_pkg::OFS_KEY);
	wire wr_stop    = reg_write & hit(reg_addr, ssr_pkg::OFS_STOP);
	wire wr_pinprot = reg_write & hit(reg_addr, ssr_pkg::OFS_PINPROT);
	wire wr_rxpin   = reg_write & hit(reg_addr, ssr_pkg::OFS_RXPIN);
	wire wr_clkpin  = reg_write & hit(reg_addr, ssr_pkg::OFS_CLKPIN);
	wire wr_irqstat = reg_write & hit(reg_addr, ssr_pkg::OFS_IRQ_STAT);
	wire wr_irqmask = reg_write & hit(reg_addr, ssr_pkg::OFS_IRQ_MASK);
	wire wr_grpen   = reg_write & hit(reg_addr, ssr_pkg::OFS_GRP_EN);
	wire wr_grpmem  = reg_write & hit(reg_addr, ssr_pkg::OFS_GRP_MEM);
	wire rd_rxdata  = reg_read  & hit(reg_addr, ssr_pkg::OFS_RXDATA);

	// key writes count only with the key code in the upper byte
	wire key_ok     = wr_key & (reg_wdata[15:8] == ssr_pkg::KEY_CODE);
	wire stop_open  = write_protect_key_reg[ssr_pkg::KEY_STOP_OPEN];
	wire pin_locked = pin_select_protect_reg[ssr_pkg::PIN_LOCK];
	wire pin_we     = pin_select_protect_reg[ssr_pkg::PIN_WE];

	// ==========================================================
	// configuration fields
	wire       rie       = serial_control_reg[ssr_pkg::CTRL_RIE];
	wire       re        = serial_control_reg[ssr_pkg::CTRL_RE];
	wire [1:0] clk_src   = serial_control_reg[1:0];
	wire       sync_mode = serial_mode_reg[ssr_pkg::MODE_SYNC];
	wire [1:0] prescale  = serial_mode_reg[1:0];
	wire       smart     = smart_interface_mode_reg[ssr_pkg::SMART_CARD];
	wire       i2c_mode  = simple_i2c_mode_reg[ssr_pkg::I2C_ENABLE];
	wire       pins_ok   = (rx_pin_function_sel == ssr_pkg::PIN_FUNC_SCI) &
	                       (clk_pin_function_sel == ssr_pkg::PIN_FUNC_SCI);

	// only the plain synchronous external-clock receiver is built; any other
	// mode combination simply holds the receiver idle
	wire rx_active = ~channel_stop_bit & re & pins_ok
	               & sync_mode                               // (RULE3)
	               & (clk_src == ssr_pkg::CKE_EXTERNAL)      // (RULE2)
	               & ~smart                                  // (RULE6)
	               & ~i2c_mode;                              // (RULE7)

	// ==========================================================
	// receive path
	logic       sample;               // sampling edge of serial clock
	logic [7:0] word;                 // assembled word
	logic       word_done;            // word complete pulse

	serial_clock_edge u_edge
	(
		.mclk     (mclk),
		.rstn     (rstn),
		.pin_clk  (serial_clock_pin),
		.polarity (simple_spi_mode_reg[ssr_pkg::SPI_POL]),
		.phase    (simple_spi_mode_reg[ssr_pkg::SPI_PHASE]),
		.sample   (sample)
	);

	rx_word_shifter #(.BITS(ssr_pkg::WORD_BITS)) u_shift
	(
		.mclk      (mclk),
		.rstn      (rstn),
		.clear     (~rx_active),
		.sample    (sample & rx_active),                              // (RULE15)
		.bit_in    (serial_rx_pin),
		.msb_first (smart_interface_mode_reg[ssr_pkg::SMART_ORDER]),  // (RULE1)
		.invert    (smart_interface_mode_reg[ssr_pkg::SMART_INVERT]), // (RULE5)
		.word      (word),
		.done      (word_done)
	);

	// a new word lands only in an empty data register
	wire accept  = word_done & ~rx_full_request_flag;                // (RULE15)
	wire overrun = word_done & rx_full_request_flag;                 // (RULE14)

	// ==========================================================
	// bit period timer: 4*(divider+1)*4^prescale clocks per bit
	wire [PERIOD_W-1:0] period_len =
		PERIOD_W'((ssr_pkg::BRG_BASE * (int'(bit_rate_divider) + 1)) << (2 * int'(prescale))); // (RULE4)
	wire restart = wr_mode | wr_bitrate;

	// software polls bit_period_done before setting receive enable
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			period_count    <= '0;
			bit_period_done <= 1'b0;
		end
		else if (restart)
		begin
			period_count    <= '0;
			bit_period_done <= 1'b0;                                 // (RULE8)
		end
		else if (!bit_period_done)
		begin
			period_count    <= period_count + PERIOD_W'(1);
			bit_period_done <= (period_count + PERIOD_W'(1) >= period_len);
		end
	end

	// ==========================================================
	// plain configuration registers, stored as written
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			serial_control_reg       <= 8'h00;
			serial_mode_reg          <= 8'h00;
			bit_rate_divider         <= ssr_pkg::BITRATE_RST;
			smart_interface_mode_reg <= 8'h00;
			simple_i2c_mode_reg      <= 8'h00;
			simple_spi_mode_reg      <= 8'h00;
			irq_mask                 <= 2'b00;
			error_group_enable       <= 1'b0;
			group_member_enable_reg  <= 1'b0;
		end
		else
		begin
			// a zero write reads back zero the next cycle
			if (wr_control) serial_control_reg       <= reg_wdata[7:0];   // (RULE9)
			if (wr_mode)    serial_mode_reg          <= reg_wdata[7:0];
			if (wr_bitrate) bit_rate_divider         <= reg_wdata[7:0];
			if (wr_smart)   smart_interface_mode_reg <= reg_wdata[7:0];
			if (wr_i2c)     simple_i2c_mode_reg      <= reg_wdata[7:0];
			if (wr_spi)     simple_spi_mode_reg      <= reg_wdata[7:0];
			if (wr_irqmask) irq_mask                 <= reg_wdata[1:0];
			if (wr_grpen)   error_group_enable       <= reg_wdata[0];
			if (wr_grpmem)  group_member_enable_reg  <= reg_wdata[0];
		end
	end

	// ==========================================================
	// protected registers: key, channel stop, pin selectors
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			write_protect_key_reg  <= 8'h00;
			channel_stop_bit       <= ssr_pkg::STOP_RST;
			pin_select_protect_reg <= ssr_pkg::PINPROT_RST;
			rx_pin_function_sel    <= 6'h00;
			clk_pin_function_sel   <= 6'h00;
		end
		else
		begin
			if (key_ok)
				write_protect_key_reg <= reg_wdata[7:0];
			// stop bit ignored unless the key opened it
			if (wr_stop && stop_open)
				channel_stop_bit <= reg_wdata[0];                      // (RULE10)
			// lock bit always writable, write enable only while unlocked
			if (wr_pinprot)
			begin
				pin_select_protect_reg[ssr_pkg::PIN_LOCK] <= reg_wdata[ssr_pkg::PIN_LOCK];
				if (!pin_locked)
					pin_select_protect_reg[ssr_pkg::PIN_WE] <= reg_wdata[ssr_pkg::PIN_WE]; // (RULE13)
			end
			if (wr_rxpin && pin_we)
				rx_pin_function_sel  <= reg_wdata[5:0];                // (RULE13)
			if (wr_clkpin && pin_we)
				clk_pin_function_sel <= reg_wdata[5:0];                // (RULE13)
		end
	end

	// ==========================================================
	// receive data and flags; a set in the clearing cycle wins
	wire clr_full = rd_rxdata | (wr_status & reg_wdata[ssr_pkg::ST_FULL]);
	wire clr_ovr  = wr_status & reg_wdata[ssr_pkg::ST_OVR];

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_data              <= 8'h00;
			rx_full_request_flag <= 1'b0;
			overrun_flag         <= 1'b0;
		end
		else
		begin
			if (accept)
				rx_data <= word;
			// reading the data clears the flag, as does a one written
			rx_full_request_flag <= accept | (rx_full_request_flag & ~clr_full); // (RULE11)
			overrun_flag         <= overrun | (overrun_flag & ~clr_ovr);         // (RULE14)
		end
	end

	// ==========================================================
	// sticky events, cleared by writing one
	wire [1:0] events = {overrun, accept};

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			irq_status <= 2'b00;
		else
			irq_status <= events | (irq_status & ~(wr_irqstat ? reg_wdata[1:0] : 2'b00));
	end

	assign irq              = |(irq_status & irq_mask);
	assign rx_full_request  = rx_full_request_flag & rie;                     // (RULE11)
	// error request needs receive interrupt enable, member enable and group enable
	assign rx_error_request = overrun_flag & rie
	                        & group_member_enable_reg & error_group_enable;   // (RULE12)

	// ==========================================================
	// read mux, unmapped indices read zero
	logic [15:0] next_rdata;

	always_comb
	begin
		next_rdata = 16'h0000;
		unique case (reg_addr)
			ssr_pkg::OFS_CONTROL:  next_rdata = {8'h00, serial_control_reg};
			ssr_pkg::OFS_MODE:     next_rdata = {8'h00, serial_mode_reg};
			ssr_pkg::OFS_BITRATE:  next_rdata = {8'h00, bit_rate_divider};
			ssr_pkg::OFS_SMART:    next_rdata = {8'h00, smart_interface_mode_reg};
			ssr_pkg::OFS_I2C:      next_rdata = {8'h00, simple_i2c_mode_reg};
			ssr_pkg::OFS_SPI:      next_rdata = {8'h00, simple_spi_mode_reg};
			ssr_pkg::OFS_RXDATA:   next_rdata = {8'h00, rx_data};
			ssr_pkg::OFS_STATUS:   next_rdata = {13'h0000, bit_period_done, overrun_flag, rx_full_request_flag};
			ssr_pkg::OFS_KEY:      next_rdata = {8'h00, write_protect_key_reg};
			ssr_pkg::OFS_STOP:     next_rdata = {15'h0000, channel_stop_bit};
			ssr_pkg::OFS_PINPROT:  next_rdata = {8'h00, pin_select_protect_reg};
			ssr_pkg::OFS_RXPIN:    next_rdata = {10'h000, rx_pin_function_sel};
			ssr_pkg::OFS_CLKPIN:   next_rdata = {10'h000, clk_pin_function_sel};
			ssr_pkg::OFS_IRQ_STAT: next_rdata = {14'h0000, irq_status};
			ssr_pkg::OFS_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
			ssr_pkg::OFS_GRP_EN:   next_rdata = {15'h0000, error_group_enable};
			ssr_pkg::OFS_GRP_MEM:  next_rdata = {15'h0000, group_member_enable_reg};
			ssr_pkg::OFS_GRP_STAT: next_rdata = {15'h0000, overrun_flag & group_member_enable_reg};
			default:               next_rdata = 16'h0000;
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_read ? next_rdata : 16'h0000;
	end

endmodule : sync_serial_slave_receiver

// file: tb/ssr_chk.sv
// port checker for the serial slave receiver
// assumes the register map and field positions of ssr_pkg
`timescale 1ns/1ps
module ssr_chk
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        serial_clock_pin,
	input wire logic        serial_rx_pin,
	input wire logic        rx_full_request,
	input wire logic        rx_error_request,
	input wire logic        irq
);
	// ==========================================
	// shadow enables, cycles since the clock pin moved
	logic       pin_q, rie, grp, mem;
	logic [1:0] msk;
	logic [3:0] quiet;   // saturates, so long idle stays large
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			{pin_q, rie, grp, mem, msk, quiet} <= '0;
		else
		begin
			pin_q <= serial_clock_pin;
			quiet <= (serial_clock_pin != pin_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
			if (reg_write && reg_addr == ssr_pkg::OFS_CONTROL) rie <= reg_wdata[ssr_pkg::CTRL_RIE];
			if (reg_write && reg_addr == ssr_pkg::OFS_GRP_EN) grp <= reg_wdata[0];
			if (reg_write && reg_addr == ssr_pkg::OFS_GRP_MEM) mem <= reg_wdata[0];
			if (reg_write && reg_addr == ssr_pkg::OFS_IRQ_MASK) msk <= reg_wdata[1:0];
		end
	end
	// ==========================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_err_gate; rx_error_request |-> rie && grp && mem; endproperty
	a_err_gate: assert property (p_err_gate) else $error("error request not gated");
	property p_full_gate; rx_full_request |-> rie; endproperty
	a_full_gate: assert property (p_full_gate) else $error("full request not gated");
	property p_irq_mask; irq |-> msk != 2'b00; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
	property p_unmapped; reg_read && reg_addr > 5'h11 |=> reg_rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_full_cause; $rose(rx_full_request) && !$past(reg_write) |-> quiet <= 4'h4; endproperty
	a_full_cause: assert property (p_full_cause) else $error("word without clock edge");
	property p_err_cause; $rose(rx_error_request) && !$past(reg_write) |-> quiet <= 4'h4; endproperty
	a_err_cause: assert property (p_err_cause) else $error("overrun without clock edge");
	property p_hold; quiet > 4'h6 && !$past(reg_write) && !$past(reg_read)
		|-> $stable(rx_full_request) && $stable(rx_error_request); endproperty
	a_hold: assert property (p_hold) else $error("request moved while idle");
	c_full: cover property ($rose(rx_full_request));
	c_err: cover property ($rose(rx_error_request));
	c_irq: cover property ($fell(irq));
endmodule : ssr_chk

bind sync_serial_slave_receiver ssr_chk u_chk (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .serial_clock_pin, .serial_rx_pin, .rx_full_request, .rx_error_request, .irq);

// file: tb/serial_master_model.sv
// behavioural clock-synchronous master for the serial pins
// assumes default phase and polarity: clock idles high, slave samples rising
`timescale 1ns/1ps
module serial_master_model
(
	input  wire logic mclk,             // system clock
	output logic      serial_clock_pin, // stands high between words
	output logic      serial_rx_pin     // data, lsb first
);
	initial
	begin
		serial_clock_pin = 1'b1;
		serial_rx_pin    = 1'b0;
	end
	// half is mclk cycles of the low clock phase, the high phase lasts half+1, so fast and slow words both occur
	task automatic send(input logic [7:0] d, input int half);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			serial_clock_pin <= 1'b0;
			serial_rx_pin    <= d[i];
			repeat (half) @(posedge mclk);
			serial_clock_pin <= 1'b1;
			repeat (half) @(posedge mclk);
		end
		serial_rx_pin <= ~d[7]; // released: never the last bit
	endtask : send
endmodule : serial_master_model

// file: tb/sync_serial_slave_receiver_tb_top.sv
// testbench for the serial slave receiver
// assumes the master model drives both serial pins
`timescale 1ns/1ps
module sync_serial_slave_receiver_tb_top;
	logic        mclk, rstn, reg_write, reg_read, serial_clock_pin, serial_rx_pin;
	logic        rx_full_request, rx_error_request, irq;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	int          fails = 0, checks = 0, cyc = 0;
	sync_serial_slave_receiver uut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .serial_clock_pin, .serial_rx_pin, .rx_full_request, .rx_error_request, .irq);
	serial_master_model m (.mclk, .serial_clock_pin, .serial_rx_pin);
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ==========================================
	// verdict, compare and register access
	task automatic stop_test();
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask : rd
	// hang guard, far above the roughly 690 cycles needed
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			stop_test();
		end
	end
	initial
	begin
		rstn      = 1'b0;
		reg_write = 1'b0;
		reg_read  = 1'b0;
		reg_addr  = 5'h00;
		reg_wdata = 16'h0000;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		rd(ssr_pkg::OFS_BITRATE, 16'h00ff);
		rd(ssr_pkg::OFS_PINPROT, 16'h0080);
		wr(ssr_pkg::OFS_STOP, 16'h0000);
		rd(ssr_pkg::OFS_STOP, 16'h0001);
		wr(ssr_pkg::OFS_KEY, 16'ha502);
		wr(ssr_pkg::OFS_STOP, 16'h0000);
		wr(ssr_pkg::OFS_KEY, 16'ha500);
		wr(ssr_pkg::OFS_STOP, 16'h0001);
		rd(ssr_pkg::OFS_STOP, 16'h0000);
		wr(ssr_pkg::OFS_RXPIN, 16'h000a);
		rd(ssr_pkg::OFS_RXPIN, 16'h0000);
		wr(ssr_pkg::OFS_PINPROT, 16'h0000);
		wr(ssr_pkg::OFS_PINPROT, 16'h0040);
		wr(ssr_pkg::OFS_RXPIN, 16'h000a);
		wr(ssr_pkg::OFS_CLKPIN, 16'h000a);
		wr(ssr_pkg::OFS_PINPROT, 16'h0080);
		wr(ssr_pkg::OFS_CLKPIN, 16'h0000);
		rd(ssr_pkg::OFS_CLKPIN, 16'h000a);
		rd(5'h1f, 16'h0000);
		wr(ssr_pkg::OFS_CONTROL, 16'h0000);
		rd(ssr_pkg::OFS_CONTROL, 16'h0000);
		wr(ssr_pkg::OFS_SMART, 16'h0000);
		wr(ssr_pkg::OFS_I2C, 16'h0000);
		wr(ssr_pkg::OFS_SPI, 16'h0000);
		wr(ssr_pkg::OFS_MODE, 16'h0080);
		wr(ssr_pkg::OFS_BITRATE, 16'h0077);
		repeat (470) @(posedge mclk);
		rd(ssr_pkg::OFS_STATUS, 16'h0000);
		repeat (20) @(posedge mclk);
		rd(ssr_pkg::OFS_STATUS, 16'h0004);
		wr(ssr_pkg::OFS_GRP_EN, 16'h0001);
		wr(ssr_pkg::OFS_GRP_MEM, 16'h0001);
		wr(ssr_pkg::OFS_IRQ_MASK, 16'h0003);
		wr(ssr_pkg::OFS_CONTROL, 16'h0052);
		m.send(8'hb4, 3);
		repeat (4) @(posedge mclk);
		#1 chk("rx_full_request", 16'h0001, 16'(rx_full_request));
		rd(ssr_pkg::OFS_RXDATA, 16'h00b4);
		#1 chk("rx_full_request", 16'h0000, 16'(rx_full_request));
		wr(ssr_pkg::OFS_SMART, 16'h000c);
		m.send(8'h3c, 1);
		m.send(8'h5a, 1);
		repeat (4) @(posedge mclk);
		#1 chk("rx_error_request", 16'h0001, 16'(rx_error_request));
		wr(ssr_pkg::OFS_GRP_EN, 16'h0000);
		#1 chk("rx_error_request", 16'h0000, 16'(rx_error_request));
		rd(ssr_pkg::OFS_STATUS, 16'h0007);
		rd(ssr_pkg::OFS_RXDATA, 16'h00c3);
		wr(ssr_pkg::OFS_STATUS, 16'h0002);
		wr(ssr_pkg::OFS_GRP_EN, 16'h0001);
		#1 chk("rx_error_request", 16'h0000, 16'(rx_error_request));
		chk("irq", 16'h0001, 16'(irq));
		wr(ssr_pkg::OFS_IRQ_MASK, 16'h0000);
		#1 chk("irq", 16'h0000, 16'(irq));
		wr(ssr_pkg::OFS_IRQ_MASK, 16'h0003);
		wr(ssr_pkg::OFS_IRQ_STAT, 16'h0003);
		#1 chk("irq", 16'h0000, 16'(irq));
		stop_test();
	end
endmodule : sync_serial_slave_receiver_tb_top
